/* ldcb_pkg.sv */
// Purpose: constants for the led dimming configuration bank
// Assumes: 8-bit register port inside the device, 125 MHz mclk
// Notes: config registers sit in the non-volatile-backed window
//
// Overview of operation
// - Bits 3:0 of the first config register are the top four bits of the 12-bit current code.
// - Bits 7:0 of the second config register are the low eight bits of the current code.
// - The current scales linearly with the code, zero to full scale in 4095 steps.
// - Full scale follows the set resistor or the full-scale selection field.
// - Bits 7:6 pick the temperature knee, codes 0 to 3 giving 1, 5, 9, 13 uA.
// - Bits 5:4 pick sink speed, codes 0 to 3 giving 800, 400, 200, 100 ns rise.
// - Third register bit 6 clear dithers only while sloping, set also dithers steadily.
// - Duty changes smaller than the chosen 1, 8, 16 or 256 step hysteresis are ignored.
// - Third register bit 3 set selects the advanced smooth slope profile.
// - Third register bits 2:0 set ramp time: immediate, then 1,2,52,105,210,315,511 ms.
// - The config window spans 60h to 78h; only 60h, 61h and 62h hold registers.
`default_nettype none
package ldcb_pkg;
    localparam logic [7:0] ADDR_UNLOCK = 8'h1A;
    localparam logic [7:0] ADDR_CFG_FIRST = 8'h60;
    localparam logic [7:0] ADDR_CFG_LAST = 8'h78;
    localparam logic [7:0] ADDR_CURRENT_HIGH = 8'h60;
    localparam logic [7:0] ADDR_CURRENT_LOW = 8'h61;
    localparam logic [7:0] ADDR_RAMP_FILTER = 8'h62;
    localparam logic [7:0] UNLOCK_CODE_A = 8'h08;
    localparam logic [7:0] UNLOCK_CODE_B = 8'hBA;
    localparam logic [7:0] UNLOCK_CODE_C = 8'hEF;
    localparam logic [7:0] RESET_CURRENT_HIGH = 8'h00;
    localparam logic [7:0] RESET_CURRENT_LOW = 8'h00;
    localparam logic [7:0] RESET_RAMP_FILTER = 8'h00;
    // field positions
    localparam int KNEE_LSB = 6;
    localparam int BIAS_LSB = 4;
    localparam int CODE_HIGH_LSB = 0;
    localparam int STEADY_DEPTH_A_BIT = 6;
    localparam int HYST_LSB = 4;
    localparam int ADV_SLOPE_BIT = 3;
    localparam int RAMP_LSB = 0;
    localparam logic [7:0] RAMP_FILTER_MASK = 8'h7F;
    // clock and ramp timing
    localparam int MCLK_KHZ = 125_000;
    localparam int CYCLES_PER_MS = MCLK_KHZ;
    localparam int RAMP_MS_1 = 1;
    localparam int RAMP_MS_2 = 2;
    localparam int RAMP_MS_3 = 52;
    localparam int RAMP_MS_4 = 105;
    localparam int RAMP_MS_5 = 210;
    localparam int RAMP_MS_6 = 315;
    localparam int RAMP_MS_7 = 511;
    // hysteresis steps at 16-bit resolution
    localparam logic [15:0] HYST_STEP_0 = 16'h0001;
    localparam logic [15:0] HYST_STEP_1 = 16'h0008;
    localparam logic [15:0] HYST_STEP_2 = 16'h0010;
    localparam logic [15:0] HYST_STEP_3 = 16'h0100;
    // knee currents in uA and rise times in ns
    localparam logic [3:0] KNEE_UA_0 = 4'h1;
    localparam logic [3:0] KNEE_UA_1 = 4'h5;
    localparam logic [3:0] KNEE_UA_2 = 4'h9;
    localparam logic [3:0] KNEE_UA_3 = 4'hD;
    localparam logic [9:0] RISE_NS_0 = 10'h320;
    localparam logic [9:0] RISE_NS_1 = 10'h190;
    localparam logic [9:0] RISE_NS_2 = 10'h0C8;
    localparam logic [9:0] RISE_NS_3 = 10'h064;

    typedef enum logic [1:0] {
        LOCKED = 2'b00,
        GOT_A = 2'b01,
        GOT_B = 2'b10,
        OPEN = 2'b11
    } ldcb_lock_t;
endpackage
`default_nettype wire

/* ldcb_pwm_hyst.sv */
// Purpose: hysteresis filter on the measured input pwm duty
// Assumes: duty comes from logic on mclk
// Notes: the held value moves only on a change at least one step wide
`timescale 1ns/1ps
`default_nettype none
module ldcb_pwm_hyst #(
    parameter int DUTY_W = 16
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [DUTY_W-1:0] dutyIn,
    input wire logic dutyValid,
    input wire logic [1:0] hystSel,
    output logic [DUTY_W-1:0] dutyOut,
    output logic dutyChanged
);
    typedef struct packed {
        logic [DUTY_W-1:0] held;
        logic changed;
    } ldcb_hyst_state_t;

    ldcb_hyst_state_t st;
    ldcb_hyst_state_t next_st;
    logic [DUTY_W-1:0] diff;
    logic [15:0] step;

    // step size from the hysteresis field and accept test
    always_comb begin
        case (hystSel)
            2'b00: step = ldcb_pkg::HYST_STEP_0;
            2'b01: step = ldcb_pkg::HYST_STEP_1;
            2'b10: step = ldcb_pkg::HYST_STEP_2;
            default: step = ldcb_pkg::HYST_STEP_3;
        endcase
        diff = (dutyIn >= st.held) ? dutyIn - st.held : st.held - dutyIn;
        next_st = st;
        next_st.changed = 1'b0;
        if (dutyValid && (diff >= DUTY_W'(step))) begin
            next_st.held = dutyIn;
            next_st.changed = 1'b1;
        end
    end

    // state register
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign dutyOut = st.held;
    assign dutyChanged = st.changed;
endmodule // ldcb_pwm_hyst
`default_nettype wire

/* ldcb_config_bank.sv */
// Purpose: non-volatile-backed dimming configuration registers
// Assumes: register port strobes come from the serial interface on mclk
// Assumes: pwm duty samples come from logic on mclk
// Notes: config writes are ignored while the bank is locked
// Notes: field decodes lag the registers by one cycle
// Notes: full-scale selection and the sink dac sit outside this block
`timescale 1ns/1ps
`default_nettype none
module ldcb_config_bank #(
    parameter int CYCLES_PER_MS = ldcb_pkg::CYCLES_PER_MS
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdata,
    output logic regRvalid,
    input wire logic [15:0] pwmDuty,
    input wire logic pwmDutyValid,
    output logic [11:0] ledCurrentCode,
    output logic [1:0] tempKneeSel,
    output logic [3:0] kneeMicroamp,
    output logic [1:0] sinkBiasSel,
    output logic [9:0] riseTimeNs,
    output logic steadyDitherEn,
    output logic advancedSlopeEn,
    output logic [2:0] rampSel,
    output logic [15:0] brightnessTarget,
    output logic sloping,
    output logic ditherActive,
    output logic unlocked
);
    typedef struct packed {
        logic [7:0] currentHigh;
        logic [7:0] currentLow;
        logic [7:0] rampFilter;
        ldcb_pkg::ldcb_lock_t lock;
        logic [7:0] rdata;
        logic rvalid;
        logic [31:0] rampLeft;
        logic [11:0] codeOut;
        logic [1:0] kneeOut;
        logic [1:0] biasOut;
        logic [3:0] kneeUa;
        logic [9:0] riseNs;
    } ldcb_state_t;

    ldcb_state_t st;
    ldcb_state_t next_st;
    logic [15:0] filtDuty;
    logic filtChanged;

    // ramp length in cycles for a slope code, zero means immediate
    function automatic logic [31:0] ramp_cycles(input logic [2:0] code);
        int ms;
        case (code)
            3'h1: ms = ldcb_pkg::RAMP_MS_1;
            3'h2: ms = ldcb_pkg::RAMP_MS_2;
            3'h3: ms = ldcb_pkg::RAMP_MS_3;
            3'h4: ms = ldcb_pkg::RAMP_MS_4;
            3'h5: ms = ldcb_pkg::RAMP_MS_5;
            3'h6: ms = ldcb_pkg::RAMP_MS_6;
            3'h7: ms = ldcb_pkg::RAMP_MS_7;
            default: ms = 0;
        endcase
        return 32'(ms * CYCLES_PER_MS);
    endfunction

    // true for an address inside the config window
    function automatic logic in_cfg(input logic [7:0] a);
        return (a >= ldcb_pkg::ADDR_CFG_FIRST) &&
            (a <= ldcb_pkg::ADDR_CFG_LAST);
    endfunction

    // knee current in microamps for a knee code
    function automatic logic [3:0] knee_ua(input logic [1:0] code);
        logic [3:0] ua;
        case (code)
            2'b00: ua = ldcb_pkg::KNEE_UA_0;
            2'b01: ua = ldcb_pkg::KNEE_UA_1;
            2'b10: ua = ldcb_pkg::KNEE_UA_2;
            default: ua = ldcb_pkg::KNEE_UA_3;
        endcase
        return ua;
    endfunction

    // typical sink rise time in ns for a bias code
    function automatic logic [9:0] rise_ns(input logic [1:0] code);
        logic [9:0] ns;
        case (code)
            2'b00: ns = ldcb_pkg::RISE_NS_0;
            2'b01: ns = ldcb_pkg::RISE_NS_1;
            2'b10: ns = ldcb_pkg::RISE_NS_2;
            default: ns = ldcb_pkg::RISE_NS_3;
        endcase
        return ns;
    endfunction

    // input duty hysteresis
    ldcb_pwm_hyst #(
        .DUTY_W(16)
    ) uHyst (
        .mclk(mclk),
        .reset(reset),
        .dutyIn(pwmDuty),
        .dutyValid(pwmDutyValid),
        .hystSel(st.rampFilter[ldcb_pkg::HYST_LSB +: 2]),
        .dutyOut(filtDuty),
        .dutyChanged(filtChanged)
    );

    // register port, unlock sequence, ramp timer and decoded fields
    always_comb begin
        // hold every field unless a branch below changes it
        next_st = st;
        // read answer pulses in the cycle after the strobe
        next_st.rvalid = regRead;
        // unlock register: three codes in order open the bank
        if (regWrite && regAddr == ldcb_pkg::ADDR_UNLOCK) begin
            case (st.lock)
                ldcb_pkg::LOCKED, ldcb_pkg::OPEN: begin
                    next_st.lock = (regWdata == ldcb_pkg::UNLOCK_CODE_A) ?
                        ldcb_pkg::GOT_A : ldcb_pkg::LOCKED;
                end
                ldcb_pkg::GOT_A: begin
                    next_st.lock = (regWdata == ldcb_pkg::UNLOCK_CODE_B) ?
                        ldcb_pkg::GOT_B : ldcb_pkg::LOCKED;
                end
                ldcb_pkg::GOT_B: begin
                    next_st.lock = (regWdata == ldcb_pkg::UNLOCK_CODE_C) ?
                        ldcb_pkg::OPEN : ldcb_pkg::LOCKED;
                end
                default: next_st.lock = ldcb_pkg::LOCKED;
            endcase
        end
        // config writes only while open
        if (regWrite && st.lock == ldcb_pkg::OPEN) begin
            case (regAddr)
                ldcb_pkg::ADDR_CURRENT_HIGH: next_st.currentHigh = regWdata;
                ldcb_pkg::ADDR_CURRENT_LOW: next_st.currentLow = regWdata;
                ldcb_pkg::ADDR_RAMP_FILTER: begin
                    // spare bit 7 is dropped on the way in
                    next_st.rampFilter = regWdata &
                        ldcb_pkg::RAMP_FILTER_MASK;
                end
                default: next_st.rampFilter = st.rampFilter;
            endcase
        end
        // read data, unmapped window words and other addresses read zero
        if (regRead) begin
            case (regAddr)
                ldcb_pkg::ADDR_CURRENT_HIGH: next_st.rdata = st.currentHigh;
                ldcb_pkg::ADDR_CURRENT_LOW: next_st.rdata = st.currentLow;
                ldcb_pkg::ADDR_RAMP_FILTER: next_st.rdata = st.rampFilter;
                default: next_st.rdata = 8'h00;
            endcase
            if (!in_cfg(regAddr)) begin
                next_st.rdata = 8'h00;
            end
        end
        // ramp timer restarts on each accepted brightness change
        if (filtChanged) begin
            next_st.rampLeft =
                ramp_cycles(st.rampFilter[ldcb_pkg::RAMP_LSB +: 3]);
        end else if (st.rampLeft != 32'h0000_0000) begin
            next_st.rampLeft = st.rampLeft - 32'h0000_0001;
        end
        // current code assembled from both registers
        next_st.codeOut = {st.currentHigh[ldcb_pkg::CODE_HIGH_LSB +: 4],
                           st.currentLow};
        next_st.kneeOut = st.currentHigh[ldcb_pkg::KNEE_LSB +: 2];
        next_st.biasOut = st.currentHigh[ldcb_pkg::BIAS_LSB +: 2];
        // knee current and rise time move together with their codes
        next_st.kneeUa = knee_ua(next_st.kneeOut);
        next_st.riseNs = rise_ns(next_st.biasOut);
    end

    // state register
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            st <= '0;
            st.currentHigh <= ldcb_pkg::RESET_CURRENT_HIGH;
            st.currentLow <= ldcb_pkg::RESET_CURRENT_LOW;
            st.rampFilter <= ldcb_pkg::RESET_RAMP_FILTER;
            st.lock <= ldcb_pkg::LOCKED;
            // reset codes are zero, so the decodes start at code zero
            st.kneeUa <= ldcb_pkg::KNEE_UA_0;
            st.riseNs <= ldcb_pkg::RISE_NS_0;
        end else begin
            st <= next_st;
        end
    end

    // outputs; the code drives the sink dac linearly, full scale set outside
    assign ledCurrentCode = st.codeOut;
    assign tempKneeSel = st.kneeOut;
    assign kneeMicroamp = st.kneeUa;
    assign sinkBiasSel = st.biasOut;
    assign riseTimeNs = st.riseNs;

    // ramp and filter register fields straight from the register
    assign steadyDitherEn = st.rampFilter[ldcb_pkg::STEADY_DEPTH_A_BIT];
    assign advancedSlopeEn = st.rampFilter[ldcb_pkg::ADV_SLOPE_BIT];
    assign rampSel = st.rampFilter[ldcb_pkg::RAMP_LSB +: 3];

    // filtered brightness, slope and depth_a state
    assign brightnessTarget = filtDuty;
    assign sloping = (st.rampLeft != 32'h0000_0000);
    assign ditherActive = sloping | steadyDitherEn;

    // lock state and read port
    assign unlocked = (st.lock == ldcb_pkg::OPEN);
    assign regRdata = st.rdata;
    assign regRvalid = st.rvalid;
endmodule // ldcb_config_bank
`default_nettype wire

/* ldcb_config_bank_properties.sv */
// Purpose: port assertions for the dimming config bank
// Assumes: one mclk domain, async active high reset
// Notes: bound to every ldcb_config_bank instance
`timescale 1ns/1ps
`default_nettype none
module ldcb_config_bank_properties (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regRdata,
    input wire logic regRvalid,
    input wire logic [11:0] ledCurrentCode,
    input wire logic [1:0] tempKneeSel,
    input wire logic [3:0] kneeMicroamp,
    input wire logic [1:0] sinkBiasSel,
    input wire logic [9:0] riseTimeNs,
    input wire logic steadyDitherEn,
    input wire logic advancedSlopeEn,
    input wire logic [2:0] rampSel,
    input wire logic sloping,
    input wire logic ditherActive,
    input wire logic unlocked
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);
    logic wrOpen;
    // a write that the bank should accept
    assign wrOpen = regWrite && unlocked;
    // register port answers
    chk_read_answer: assert property (regRead |=> regRvalid)
        else $error("read not answered");
    chk_valid_cause: assert property (regRvalid |-> $past(regRead))
        else $error("answer without read");
    chk_outside_zero: assert property
        (regRead && (regAddr < 8'h60 || regAddr > 8'h62) |=> regRdata == 8'h00)
        else $error("unmapped read not zero");
    chk_spare_bit: assert property
        (regRead && regAddr == 8'h62 |=> !regRdata[7])
        else $error("spare bit reads one");
    // field outputs follow accepted writes
    chk_code_high: assert property (wrOpen && regAddr == 8'h60 |->
        ##2 ledCurrentCode[11:8] == $past(regWdata[3:0], 2))
        else $error("code high nibble wrong");
    chk_code_low: assert property (wrOpen && regAddr == 8'h61 |->
        ##2 ledCurrentCode[7:0] == $past(regWdata, 2))
        else $error("code low byte wrong");
    chk_knee_map: assert property
        (kneeMicroamp == 4'h1 + {tempKneeSel, 2'b00})
        else $error("knee current wrong");
    chk_rise_map: assert property
        (riseTimeNs == (10'h320 >> sinkBiasSel))
        else $error("rise time wrong");
    chk_ramp_fields: assert property (wrOpen && regAddr == 8'h62 |=>
        {steadyDitherEn, advancedSlopeEn, rampSel} ==
        {$past(regWdata[6]), $past(regWdata[3:0])})
        else $error("ramp fields wrong");
    chk_depth_a_or: assert property
        (ditherActive == (sloping || steadyDitherEn))
        else $error("depth_a state wrong");
    chk_slope_cause: assert property
        ($rose(sloping) |-> $past(rampSel) != 3'h0)
        else $error("slope with ramp off");
    // main scenarios reached
    cov_unlock: cover property ($rose(unlocked));
    cov_slope: cover property ($fell(sloping));
    cov_ctrl_read: cover property (regRead && regAddr == 8'h62);
endmodule // ldcb_config_bank_properties
bind ldcb_config_bank ldcb_config_bank_properties i_chk (
    .mclk(mclk), .reset(reset), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .regRvalid(regRvalid), .ledCurrentCode(ledCurrentCode),
    .tempKneeSel(tempKneeSel), .kneeMicroamp(kneeMicroamp),
    .sinkBiasSel(sinkBiasSel), .riseTimeNs(riseTimeNs),
    .steadyDitherEn(steadyDitherEn), .advancedSlopeEn(advancedSlopeEn),
    .rampSel(rampSel), .sloping(sloping), .ditherActive(ditherActive),
    .unlocked(unlocked)
);
`default_nettype wire

/* ldcb_host_model.sv */
// Purpose: register port host for the config bank
// Assumes: one-cycle strobes launched after mclk edges
// Notes: write data is inverted once the strobe drops
`timescale 1ns/1ps
`default_nettype none
module ldcb_host_model (
    input wire logic mclk,
    output logic [7:0] regAddr,
    output logic [7:0] regWdata,
    output logic regWrite,
    output logic regRead,
    input wire logic [7:0] regRdata,
    input wire logic regRvalid
);
    // idle port at time zero
    initial begin
        regAddr = 8'h00;
        regWdata = 8'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
    end
    // one write strobe, then stale data is scrambled
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge mclk);
        regWrite <= 1'b0;
        regWdata <= ~d;
    endtask
    // one read strobe, answer taken one edge later
    task automatic rd(input logic [7:0] a, output logic [8:0] r);
        @(posedge mclk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge mclk);
        regRead <= 1'b0;
        @(posedge mclk);
        r = {regRvalid, regRdata};
    endtask
    // three-byte sequence that opens the bank
    task automatic unlock();
        wr(8'h1A, ldcb_pkg::UNLOCK_CODE_A);
        wr(8'h1A, ldcb_pkg::UNLOCK_CODE_B);
        wr(8'h1A, ldcb_pkg::UNLOCK_CODE_C);
    endtask
endmodule // ldcb_host_model
`default_nettype wire

/* test_led_dimming_config_bank.sv */
// Purpose: self-checking bench for the dimming config bank
// Assumes: short millisecond count of 4 cycles
// Notes: host model drives the register port
`timescale 1ns/1ps
`default_nettype none
module test_led_dimming_config_bank;
    localparam int CPM = 4;
    logic mclk, reset, regWrite, regRead, regRvalid, pwmDutyValid;
    logic [7:0] regAddr, regWdata, regRdata;
    logic [15:0] pwmDuty, brightnessTarget;
    logic [11:0] ledCurrentCode;
    logic [1:0] tempKneeSel, sinkBiasSel;
    logic [3:0] kneeMicroamp;
    logic [9:0] riseTimeNs;
    logic [2:0] rampSel;
    logic steadyDitherEn, advancedSlopeEn, sloping, ditherActive, unlocked;
    logic [8:0] r;
    int mismatches = 0;
    int comparisons = 0;
    ldcb_config_bank #(.CYCLES_PER_MS(CPM)) i_dut (.mclk(mclk), .reset(reset),
        .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
        .regRead(regRead), .regRdata(regRdata), .regRvalid(regRvalid),
        .pwmDuty(pwmDuty), .pwmDutyValid(pwmDutyValid),
        .ledCurrentCode(ledCurrentCode), .tempKneeSel(tempKneeSel),
        .kneeMicroamp(kneeMicroamp), .sinkBiasSel(sinkBiasSel),
        .riseTimeNs(riseTimeNs), .steadyDitherEn(steadyDitherEn),
        .advancedSlopeEn(advancedSlopeEn), .rampSel(rampSel),
        .brightnessTarget(brightnessTarget), .sloping(sloping),
        .ditherActive(ditherActive), .unlocked(unlocked));
    ldcb_host_model h (.mclk(mclk), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .regRvalid(regRvalid));
    // clock, 8 ns period
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    // value comparison
    task automatic cmp(input string n, input logic [15:0] e,
        input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic results();
        if (mismatches == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // locked bank ignores writes
    task automatic t_locked();
        h.wr(8'h60, 8'hFF);
        h.rd(8'h60, r);
        cmp("locked60", 16'h0100, 16'(r));
    endtask
    // every knee and bias code, current code boundaries
    task automatic t_fields();
        logic [3:0] kn[4] = '{4'h1, 4'h5, 4'h9, 4'hD};
        logic [9:0] rs[4] = '{10'h320, 10'h190, 10'h0C8, 10'h064};
        h.unlock();
        @(posedge mclk); // last code lands at the edge the task ends on
        cmp("unlocked", 16'h0001, 16'(unlocked));
        for (int i = 0; i < 4; i++) begin
            h.wr(8'h60, {4{2'(i)}});
            h.wr(8'h61, {4{2'(i)}});
            repeat (3) @(posedge mclk);
            cmp("code", 16'({6{2'(i)}}), 16'(ledCurrentCode));
            cmp("knee", 16'(kn[i]), 16'(kneeMicroamp));
            cmp("rise", 16'(rs[i]), 16'(riseTimeNs));
            cmp("kneeSel", 16'(i), 16'(tempKneeSel));
            cmp("biasSel", 16'(i), 16'(sinkBiasSel));
        end
    endtask
    // control register and its spare bit
    task automatic t_ctrl();
        h.wr(8'h62, 8'hFF);
        h.rd(8'h62, r);
        cmp("ctrl", 16'h017F, 16'(r));
        cmp("flags", 16'h001F,
            16'({steadyDitherEn, advancedSlopeEn, rampSel}));
        cmp("depth_a", 16'h0001, 16'(ditherActive));
    endtask
    // unmapped places read zero
    task automatic t_unmapped();
        logic [7:0] ad[5] = '{8'h1A, 8'h5F, 8'h63, 8'h78, 8'hFF};
        foreach (ad[k]) begin
            h.rd(ad[k], r);
            cmp("unmapped", 16'h0100, 16'(r));
        end
    endtask
    // one duty sample, slope cycles counted
    task automatic duty(input logic [15:0] d, input logic [15:0] t,
        input int s);
        int c;
        int dc;
        c = 0;
        dc = 0;
        @(posedge mclk);
        pwmDuty <= d;
        pwmDutyValid <= 1'b1;
        @(posedge mclk);
        pwmDutyValid <= 1'b0;
        repeat (12) begin
            @(posedge mclk);
            c += int'(sloping);
            dc += int'(ditherActive);
        end
        cmp("target", t, brightnessTarget);
        cmp("slope", 16'(s), 16'(c));
        cmp("depth_a", 16'(s), 16'(dc));
    endtask
    // reset values of the three registers and their decodes
    task automatic t_reset();
        for (int a = 8'h60; a < 8'h63; a++) begin
            h.rd(8'(a), r);
            cmp("reset", 16'h0100, 16'(r));
        end
        cmp("kneeRst", 16'h0001, 16'(kneeMicroamp));
        cmp("riseRst", 16'h0320, 16'(riseTimeNs));
    endtask
    // every hysteresis code at its edge, slope codes 0 to 2
    task automatic t_duty();
        h.wr(8'h62, 8'h21);
        duty(16'h0100, 16'h0100, CPM);
        duty(16'h010F, 16'h0100, 0);
        duty(16'h0110, 16'h0110, CPM);
        h.wr(8'h62, 8'h20);
        duty(16'h0200, 16'h0200, 0);
        h.wr(8'h62, 8'h30);
        duty(16'h02FF, 16'h0200, 0);
        duty(16'h0300, 16'h0300, 0);
        h.wr(8'h62, 8'h12);
        duty(16'h0307, 16'h0300, 0);
        duty(16'h0308, 16'h0308, 2 * CPM);
        h.wr(8'h62, 8'h00);
        duty(16'h0309, 16'h0309, 0);
    endtask
    // a wrong unlock code locks the bank again
    task automatic t_relock();
        h.wr(8'h1A, 8'h00);
        h.wr(8'h60, 8'h77);
        h.rd(8'h60, r);
        cmp("relock", 16'h01FF, 16'(r));
        cmp("locked", 16'h0000, 16'(unlocked));
    endtask
    // main sequence
    initial begin
        reset = 1'b1;
        pwmDuty = 16'h0000;
        pwmDutyValid = 1'b0;
        repeat (4) @(posedge mclk);
        reset <= 1'b0;
        t_reset();
        t_locked();
        t_fields();
        t_ctrl();
        t_unmapped();
        t_duty();
        t_relock();
        results();
    end
    // watchdog
    initial begin
        repeat (3000) @(posedge mclk);
        mismatches++;
        results();
    end
endmodule // test_led_dimming_config_bank
`default_nettype wire
